/* File: rtl/nae_alu.sv */
// Nibble adder, subtractor and bitwise unit
`timescale 1ns/100ps
`default_nettype none
module nae_alu import nae_pkg::*; (
    input  wire nae_alu_e      op,
    input  wire logic [DW-1:0] a,
    input  wire logic [DW-1:0] b,
    input  wire logic          cin,
    input  wire logic          useCin,
    output logic [DW-1:0]      result,
    output logic               carryOut
);
    logic [DW:0] wide;
    logic [DW:0] cinExt;

    always_comb begin
        cinExt   = {{DW{1'b0}}, useCin & cin};
        wide     = '0;
        result   = NIB_ZERO;
        carryOut = cin;
        case (op)
            ALU_ADD: begin
                wide     = {1'b0, a} + {1'b0, b} + cinExt;
                result   = wide[DW-1:0];
                carryOut = wide[DW];
            end
            ALU_SUB: begin
                // Carry reads as no-borrow after a subtraction
                wide     = {1'b0, a} - {1'b0, b} - cinExt;
                result   = wide[DW-1:0];
                carryOut = ~wide[DW];
            end
            ALU_AND: result = a & b;
            ALU_OR:  result = a | b;
            ALU_XOR: result = a ^ b;
            default: result = NIB_ZERO;
        endcase
    end
endmodule : nae_alu
`default_nettype wire

/* File: rtl/nae_exec.sv */
// Decode and single-cycle execution of arithmetic, logic, branch and skip instructions
`timescale 1ns/100ps
`default_nettype none
// Function
// [RULE1] Add memory nibble to accumulator into accumulator, zero and carry updated.
// [RULE2] Write-back add stores the sum to accumulator and memory, flags updated.
// [RULE3] Add with carry sums memory, accumulator and carry into accumulator.
// [RULE4] Write-back add with carry also stores the sum to memory.
// [RULE5] Keep-carry adds change only the zero flag, carry untouched.
// [RULE6] Subtract memory minus accumulator; write-back form stores to memory too.
// [RULE7] Borrow subtracts also take away the carry; write-back stores the result.
// [RULE8] Immediate forms take a 4-bit constant and one of sixteen working registers.
// [RULE9] AND, OR, XOR update only zero; write-back forms store the result.
// [RULE10] Far jump loads bank times 800H plus the 11-bit address.
// [RULE11] Accumulator bit jumps load the low 11 PC bits when the bit is one.
// [RULE12] Zero jumps load the low 11 PC bits on accumulator zero or nonzero.
// [RULE13] Carry jumps load the low 11 PC bits on carry set or clear.
// [RULE14] Decrement-and-skip writes memory and accumulator and skips on zero or nonzero.
// [RULE15] Bit-test skip passes one word when the memory bit is one, flags kept.
// [RULE16] Increment and decrement write memory plus or minus one to both places.
// [RULE17] Paged address is page low three bits times 10H plus the offset.
// [RULE18] One word per instruction, one cycle each; a skip passes one word.
// [RULE19] Zero flag marks a zero result; carry means carry-out or no-borrow.
module nae_exec import nae_pkg::*; (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    input  wire logic             instValid,
    input  wire logic [15:0]      instWord,
    input  wire logic [DW-1:0]    ramRdata,
    input  wire logic [PBW-1:0]   programBank,
    input  wire logic [PBW-1:0]   workPage,
    output var nae_ram_s          ramPort,
    output logic [DW-1:0]         accumulator,
    output logic                  zeroFlag,
    output logic                  carryFlag,
    output logic [PCW-1:0]        pc
);
    nae_dec_s        dec;
    logic [3:0]      hi;
    logic            fire;
    logic [DW-1:0]   operandB;
    logic [DW-1:0]   aluResult;
    logic            aluCarry;
    logic            accZero;
    logic            condTrue;
    logic            skipTaken;
    logic            jumpFar;
    logic            jumpNear;
    logic [PCW-1:0]  next_pc;

    assign hi   = instWord[HI_MSB:HI_LSB];
    assign fire = ce & instValid;

    // Decode; anything outside this group decodes to no operation
    always_comb begin
        dec           = '0;
        dec.cls       = CLS_NONE;
        dec.op        = ALU_ADD;
        dec.srcB      = SRCB_ACC;
        dec.cond      = COND_BIT;
        dec.skip      = SKIP_NONE;
        dec.imm       = instWord[IMM_MSB:IMM_LSB];
        dec.wrIdx     = instWord[WR_MSB:0];
        dec.memAddr   = instWord[RA_MSB:0];
        dec.target    = instWord[LW-1:0];
        dec.bitSel    = hi[1:0];
        if (instWord[GRP_BIT]) begin
            case (hi)
                HI_ADC, HI_ADD, HI_ADU, HI_XRL: begin
                    if (instWord[IMM_BIT] || !instWord[R7_BIT]) begin
                        dec.cls       = CLS_ALU;
                        dec.immForm   = instWord[IMM_BIT]; // [RULE8]
                        dec.srcB      = instWord[IMM_BIT] ? SRCB_IMM : SRCB_ACC;
                        dec.writeBack = instWord[WB_BIT]; // [RULE2] [RULE4]
                        case (hi)
                            HI_ADC: begin
                                dec.op       = instWord[SEL_BIT] ? ALU_SUB : ALU_ADD; // [RULE7]
                                dec.useCarry = 1'b1; // [RULE3]
                                dec.updCarry = 1'b1;
                            end
                            HI_ADD: begin
                                dec.op       = instWord[SEL_BIT] ? ALU_SUB : ALU_ADD; // [RULE6]
                                dec.updCarry = 1'b1; // [RULE1]
                            end
                            HI_ADU: begin
                                dec.op       = instWord[SEL_BIT] ? ALU_AND : ALU_ADD; // [RULE5]
                                dec.updCarry = 1'b0;
                            end
                            default: begin
                                dec.op       = instWord[SEL_BIT] ? ALU_OR : ALU_XOR; // [RULE9]
                                dec.updCarry = 1'b0;
                            end
                        endcase
                    end
                end
                HI_INC: begin
                    if (!instWord[IMM_BIT] && !instWord[SEL_BIT] && !instWord[WB_BIT]) begin
                        dec.cls       = CLS_ALU;
                        dec.op        = ALU_SUB;
                        dec.srcB      = SRCB_ONE;
                        dec.writeBack = 1'b1;
                        dec.updCarry  = 1'b1;
                        dec.skip      = instWord[R7_BIT] ? SKIP_NZ : SKIP_Z; // [RULE14]
                    end else if (!instWord[IMM_BIT] && instWord[SEL_BIT] && !instWord[WB_BIT]) begin
                        dec.cls       = CLS_ALU;
                        dec.op        = instWord[R7_BIT] ? ALU_SUB : ALU_ADD; // [RULE16]
                        dec.srcB      = SRCB_ONE;
                        dec.writeBack = 1'b1;
                        dec.updCarry  = 1'b1;
                    end
                end
                HI_SKB: begin
                    if (!instWord[IMM_BIT] && !instWord[SEL_BIT]) begin
                        dec.cls    = CLS_SKB;
                        dec.bitSel = {instWord[WB_BIT], instWord[R7_BIT]}; // [RULE15]
                    end
                end
                default: dec.cls = CLS_NONE;
            endcase
        end else begin
            case (hi)
                HI_JMP: dec.cls = CLS_JMP;
                HI_JB0, HI_JB1, HI_JB2, HI_JB3: begin
                    dec.cls  = CLS_JCOND;
                    dec.cond = COND_BIT; // [RULE11]
                end
                HI_JZ: begin
                    dec.cls  = CLS_JCOND;
                    dec.cond = COND_Z; // [RULE12]
                end
                HI_JNZ: begin
                    dec.cls  = CLS_JCOND;
                    dec.cond = COND_NZ; // [RULE12]
                end
                HI_JC: begin
                    dec.cls  = CLS_JCOND;
                    dec.cond = COND_C; // [RULE13]
                end
                HI_JNC: begin
                    dec.cls  = CLS_JCOND;
                    dec.cond = COND_NC; // [RULE13]
                end
                default: dec.cls = CLS_NONE;
            endcase
        end
    end

    // Working registers live in RAM, so immediate forms read them through the page
    always_comb begin
        ramPort.addr  = dec.immForm ? nae_paged_addr(workPage, dec.wrIdx) // [RULE17]
                                    : dec.memAddr;
        ramPort.wdata = aluResult;
        ramPort.we    = fire && (dec.cls == CLS_ALU) && dec.writeBack; // [RULE2]
    end

    always_comb begin
        case (dec.srcB)
            SRCB_IMM: operandB = dec.imm; // [RULE8]
            SRCB_ONE: operandB = NIB_ONE;
            default:  operandB = accumulator;
        endcase
    end

    nae_alu u_alu (
        .op       (dec.op),
        .a        (ramRdata),
        .b        (operandB),
        .cin      (carryFlag),
        .useCin   (dec.useCarry),
        .result   (aluResult),
        .carryOut (aluCarry)
    );

    assign accZero = nae_is_zero(accumulator);

    always_comb begin
        case (dec.cond)
            COND_Z:  condTrue = accZero;
            COND_NZ: condTrue = !accZero;
            COND_C:  condTrue = carryFlag;
            COND_NC: condTrue = !carryFlag;
            default: condTrue = accumulator[dec.bitSel];
        endcase
    end

    always_comb begin
        skipTaken = 1'b0;
        if (dec.cls == CLS_SKB) begin
            skipTaken = ramRdata[dec.bitSel]; // [RULE15]
        end else if (dec.cls == CLS_ALU) begin
            if (dec.skip == SKIP_Z) begin
                skipTaken = nae_is_zero(aluResult); // [RULE14]
            end else if (dec.skip == SKIP_NZ) begin
                skipTaken = !nae_is_zero(aluResult);
            end
        end
    end

    assign jumpFar  = (dec.cls == CLS_JMP);
    assign jumpNear = (dec.cls == CLS_JCOND) && condTrue;

    nae_pc_next u_pc_next (
        .pc          (pc),
        .programBank (programBank),
        .target      (dec.target),
        .jumpFar     (jumpFar),
        .jumpNear    (jumpNear),
        .skip        (skipTaken),
        .nextPc      (next_pc)
    );

    // Every instruction of the group takes exactly one enabled cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc <= PC_RST;
        end else if (fire) begin
            pc <= next_pc; // [RULE18]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            accumulator <= ACC_RST;
        end else if (fire && dec.cls == CLS_ALU) begin
            accumulator <= aluResult; // [RULE1] [RULE3]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            zeroFlag <= 1'b0;
        end else if (fire && dec.cls == CLS_ALU) begin
            zeroFlag <= nae_is_zero(aluResult); // [RULE19]
        end
    end

    // Logic and keep-carry forms must not disturb a pending multi-nibble carry
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            carryFlag <= 1'b0;
        end else if (fire && dec.cls == CLS_ALU && dec.updCarry) begin
            carryFlag <= aluCarry; // [RULE5] [RULE19]
        end
    end

    a_add_acc: assert property (@(posedge clk) disable iff (!rstn) // [RULE1]
        fire && dec.cls == CLS_ALU && dec.op == ALU_ADD && dec.srcB == SRCB_ACC && !dec.useCarry
        |=> accumulator == DW'($past(ramRdata) + $past(accumulator)))
        else $error("plain add result wrong");

    a_wb_store: assert property (@(posedge clk) disable iff (!rstn) // [RULE2]
        fire && dec.cls == CLS_ALU && dec.writeBack
        |-> ramPort.we ##1 accumulator == $past(ramPort.wdata))
        else $error("write-back not issued");

    a_adc_sum: assert property (@(posedge clk) disable iff (!rstn) // [RULE3]
        fire && dec.cls == CLS_ALU && dec.op == ALU_ADD && dec.useCarry && dec.srcB == SRCB_ACC
        |=> {carryFlag, accumulator} == ({1'b0, $past(ramRdata)} + {1'b0, $past(accumulator)}
                                         + {4'h0, $past(carryFlag)}))
        else $error("add with carry wrong");

    a_keep_carry: assert property (@(posedge clk) disable iff (!rstn) // [RULE5]
        fire && dec.cls == CLS_ALU && !dec.updCarry |=> $stable(carryFlag))
        else $error("carry changed by keep-carry form");

    a_sub_borrow: assert property (@(posedge clk) disable iff (!rstn) // [RULE6]
        fire && dec.cls == CLS_ALU && dec.op == ALU_SUB && dec.srcB == SRCB_ACC && !dec.useCarry
        |=> carryFlag == ($past(ramRdata) >= $past(accumulator)))
        else $error("subtract no-borrow wrong");

    a_imm_addr: assert property (@(posedge clk) disable iff (!rstn) // [RULE17]
        dec.immForm |-> ramPort.addr == RAW'(workPage) * PAGE_STRIDE + RAW'(instWord[WR_MSB:0]))
        else $error("paged address wrong");

    a_zero_flag: assert property (@(posedge clk) disable iff (!rstn) // [RULE19]
        fire && dec.cls == CLS_ALU |=> zeroFlag == (accumulator == NIB_ZERO))
        else $error("zero flag mismatch");

    a_far_jump: assert property (@(posedge clk) disable iff (!rstn) // [RULE10]
        fire && dec.cls == CLS_JMP
        |=> pc == $past(programBank) * BANK_STRIDE + PCW'($past(instWord[LW-1:0])))
        else $error("far jump target wrong");

    a_jz_taken: assert property (@(posedge clk) disable iff (!rstn) // [RULE12]
        fire && dec.cls == CLS_JCOND && dec.cond == COND_Z && accZero
        |=> pc[LW-1:0] == $past(instWord[LW-1:0]) && $stable(pc[PCW-1:LW]))
        else $error("zero jump not taken");

    a_jc_fall: assert property (@(posedge clk) disable iff (!rstn) // [RULE13]
        fire && dec.cls == CLS_JCOND && dec.cond == COND_C && !carryFlag
        |=> pc == $past(pc) + STEP_ONE)
        else $error("carry jump taken without carry");

    a_bit_skip: assert property (@(posedge clk) disable iff (!rstn) // [RULE15]
        fire && dec.cls == CLS_SKB && ramRdata[dec.bitSel]
        |=> pc == $past(pc) + STEP_SKIP && $stable(zeroFlag) && $stable(carryFlag))
        else $error("bit skip wrong");

    a_dsk_skip: assert property (@(posedge clk) disable iff (!rstn) // [RULE14]
        fire && dec.cls == CLS_ALU && dec.skip == SKIP_Z && ramRdata == NIB_ONE
        |-> ramPort.we ##1 pc == $past(pc) + STEP_SKIP && accZero)
        else $error("decrement skip wrong");

    a_ce_freeze: assert property (@(posedge clk) disable iff (!rstn) // [RULE18]
        !ce |=> $stable(pc) && $stable(accumulator) && $stable(carryFlag))
        else $error("state moved with enable low");

    a_sub_acc: assert property (@(posedge clk) disable iff (!rstn) // [RULE6]
        fire && dec.cls == CLS_ALU && dec.op == ALU_SUB && !dec.useCarry
        |=> accumulator == DW'($past(ramRdata) - $past(operandB)))
        else $error("subtract result wrong");

    a_sbc_sum: assert property (@(posedge clk) disable iff (!rstn) // [RULE7]
        fire && dec.cls == CLS_ALU && dec.op == ALU_SUB && dec.useCarry
        |=> {!carryFlag, accumulator} == ({1'b0, $past(ramRdata)} - {1'b0, $past(operandB)}
                                          - {4'h0, $past(carryFlag)}))
        else $error("borrow subtract wrong");

    a_logic_and: assert property (@(posedge clk) disable iff (!rstn) // [RULE9]
        fire && dec.cls == CLS_ALU && dec.op == ALU_AND
        |=> accumulator == ($past(ramRdata) & $past(operandB))
            && $stable(carryFlag))
        else $error("logic result wrong");

    a_bit_jump: assert property (@(posedge clk) disable iff (!rstn) // [RULE11]
        fire && dec.cls == CLS_JCOND && dec.cond == COND_BIT && accumulator[dec.bitSel]
        |=> pc[LW-1:0] == $past(instWord[LW-1:0]))
        else $error("bit jump not taken");

    a_jnz_fall: assert property (@(posedge clk) disable iff (!rstn) // [RULE12]
        fire && dec.cls == CLS_JCOND && dec.cond == COND_NZ && accZero
        |=> pc == $past(pc) + STEP_ONE)
        else $error("nonzero jump taken on zero");

    a_inc_store: assert property (@(posedge clk) disable iff (!rstn) // [RULE16]
        fire && dec.cls == CLS_ALU && dec.srcB == SRCB_ONE && dec.op == ALU_ADD
        |-> ramPort.we
            && ramPort.wdata == ramRdata + NIB_ONE)
        else $error("increment store wrong");
endmodule : nae_exec
`default_nettype wire

/* File: rtl/nae_pc_next.sv */
// Next program counter selection for jumps and skips
`timescale 1ns/100ps
`default_nettype none
module nae_pc_next import nae_pkg::*; (
    input  wire logic [PCW-1:0] pc,
    input  wire logic [PBW-1:0] programBank,
    input  wire logic [LW-1:0]  target,
    input  wire logic           jumpFar,
    input  wire logic           jumpNear,
    input  wire logic           skip,
    output logic [PCW-1:0]      nextPc
);
    always_comb begin
        if (jumpFar) begin
            nextPc = PCW'(programBank) * BANK_STRIDE + PCW'(target); // [RULE10]
        end else if (jumpNear) begin
            // Near jumps stay inside the current 2K block
            nextPc = {pc[PCW-1:LW], target}; // [RULE11]
        end else if (skip) begin
            nextPc = pc + STEP_SKIP; // [RULE18]
        end else begin
            nextPc = pc + STEP_ONE;
        end
    end
endmodule : nae_pc_next
`default_nettype wire

/* File: rtl/nae_pkg.sv */
// Shared constants, types and helpers of the nibble ALU and branch executor
package nae_pkg;
    localparam int DW  = 4;
    localparam int PCW = 14;
    localparam int RAW = 7;
    localparam int LW  = 11;
    localparam int PBW = 3;

    localparam logic [DW-1:0]  ACC_RST     = 4'h0;
    localparam logic [PCW-1:0] PC_RST      = 14'h0000;
    localparam logic [RAW-1:0] PAGE_STRIDE = 7'h10;
    localparam logic [PCW-1:0] BANK_STRIDE = 14'h0800;
    localparam logic [PCW-1:0] STEP_ONE    = 14'h0001;
    localparam logic [PCW-1:0] STEP_SKIP   = 14'h0002;
    localparam logic [DW-1:0]  NIB_ONE     = 4'h1;
    localparam logic [DW-1:0]  NIB_ZERO    = 4'h0;

    // Instruction word fields
    localparam int HI_MSB  = 15;
    localparam int HI_LSB  = 12;
    localparam int GRP_BIT = 11;
    localparam int IMM_BIT = 10;
    localparam int SEL_BIT = 9;
    localparam int WB_BIT  = 8;
    localparam int R7_BIT  = 7;
    localparam int IMM_MSB = 7;
    localparam int IMM_LSB = 4;
    localparam int WR_MSB  = 3;
    localparam int RA_MSB  = 6;

    localparam logic [3:0] HI_ADC = 4'h0;
    localparam logic [3:0] HI_ADD = 4'h1;
    localparam logic [3:0] HI_ADU = 4'h2;
    localparam logic [3:0] HI_XRL = 4'h3;
    localparam logic [3:0] HI_INC = 4'h4;
    localparam logic [3:0] HI_JMP = 4'h7;
    localparam logic [3:0] HI_JB0 = 4'h8;
    localparam logic [3:0] HI_JB1 = 4'h9;
    localparam logic [3:0] HI_JB2 = 4'hA;
    localparam logic [3:0] HI_JB3 = 4'hB;
    localparam logic [3:0] HI_SKB = 4'hA;
    localparam logic [3:0] HI_JNZ = 4'hC;
    localparam logic [3:0] HI_JNC = 4'hD;
    localparam logic [3:0] HI_JZ  = 4'hE;
    localparam logic [3:0] HI_JC  = 4'hF;

    typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR} nae_alu_e;
    typedef enum logic [1:0] {SRCB_ACC, SRCB_IMM, SRCB_ONE} nae_srcb_e;
    typedef enum logic [2:0] {CLS_NONE, CLS_ALU, CLS_JMP, CLS_JCOND, CLS_SKB} nae_cls_e;
    typedef enum logic [2:0] {COND_BIT, COND_Z, COND_NZ, COND_C, COND_NC} nae_cond_e;
    typedef enum logic [1:0] {SKIP_NONE, SKIP_Z, SKIP_NZ} nae_skip_e;

    typedef struct packed {
        nae_cls_e        cls;
        nae_alu_e        op;
        nae_srcb_e       srcB;
        nae_cond_e       cond;
        nae_skip_e       skip;
        logic            useCarry;
        logic            updCarry;
        logic            writeBack;
        logic            immForm;
        logic [1:0]      bitSel;
        logic [DW-1:0]   imm;
        logic [3:0]      wrIdx;
        logic [RAW-1:0]  memAddr;
        logic [LW-1:0]   target;
    } nae_dec_s;

    typedef struct packed {
        logic [RAW-1:0] addr;
        logic [DW-1:0]  wdata;
        logic           we;
    } nae_ram_s;

    function automatic logic [RAW-1:0] nae_paged_addr(input logic [PBW-1:0] page,
                                                      input logic [3:0] idx);
        nae_paged_addr = RAW'(page) * PAGE_STRIDE + RAW'(idx);
    endfunction : nae_paged_addr

    function automatic logic nae_is_zero(input logic [DW-1:0] n);
        nae_is_zero = (n == NIB_ZERO);
    endfunction : nae_is_zero
endpackage : nae_pkg

/* File: tb/tb_top.sv */
// Self-checking bench for the nibble ALU and branch executor
`timescale 1ns/100ps
`default_nettype none
module tb_top import nae_pkg::*;;
    logic           clk;
    logic           rstn;
    logic           ce;
    logic           instValid;
    logic [15:0]    instWord;
    logic [DW-1:0]  ramRdata;
    logic [PBW-1:0] programBank;
    logic [PBW-1:0] workPage;
    nae_ram_s       ramPort;
    logic [DW-1:0]  accumulator;
    logic           zeroFlag;
    logic           carryFlag;
    logic [PCW-1:0] pc;
    logic [DW-1:0]  mem [128];
    logic [DW-1:0]  eAcc;
    logic           eZ;
    logic           eC;
    logic [PCW-1:0] ePc;
    int             nFail;
    int             checked;

    nae_exec u_dut (
        .clk(clk), .rstn(rstn), .ce(ce), .instValid(instValid), .instWord(instWord),
        .ramRdata(ramRdata), .programBank(programBank), .workPage(workPage),
        .ramPort(ramPort), .accumulator(accumulator), .zeroFlag(zeroFlag),
        .carryFlag(carryFlag), .pc(pc)
    );

    // Asynchronous-read data RAM, written at the edge that takes the instruction
    assign ramRdata = mem[ramPort.addr];
    always @(posedge clk) if (ramPort.we) mem[ramPort.addr] <= ramPort.wdata;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d fails %0d", checked, nFail);
        if (nFail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
        checked++;
        if (g !== e) begin
            nFail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic chk_state();
        chk("accumulator", 14'(eAcc), 14'(accumulator));
        chk("zeroFlag", 14'(eZ), 14'(zeroFlag));
        chk("carryFlag", 14'(eC), 14'(carryFlag));
        chk("pc", ePc, pc);
    endtask : chk_state

    // Presets the operand nibble, predicts the result, executes one word and compares
    task automatic run(input logic [15:0] w, input logic [3:0] m);
        logic [6:0]     a;
        logic [3:0]     b;
        logic [3:0]     hi;
        logic [4:0]     s;
        logic           wb;
        logic           t;
        logic [PCW-1:0] nPc;
        hi = w[15:12];
        a = (w[11] && w[10]) ? {workPage, w[3:0]} : w[6:0];
        mem[a] = m;
        b = w[10] ? w[7:4] : eAcc;
        wb = 1'b0;
        s = {1'b0, m};
        nPc = ePc + 14'h1;
        if (!w[11] && hi >= 4'h7) begin
            case (hi)
                4'h7: t = 1'b1;
                4'hC: t = (eAcc != 4'h0);
                4'hD: t = !eC;
                4'hE: t = (eAcc == 4'h0);
                4'hF: t = eC;
                default: t = eAcc[hi[1:0]];
            endcase
            if (hi == 4'h7) nPc = {programBank, w[10:0]};
            else if (t) nPc = {ePc[13:11], w[10:0]};
        end else if (w[11] && hi == 4'hA) begin
            if (m[{w[8], w[7]}]) nPc = ePc + 14'h2;
        end else if (w[11] && hi == 4'h4) begin
            s = (w[9] && !w[7]) ? m + 5'h1 : m - 5'h1;
            eC = (w[9] && !w[7]) ? s[4] : !s[4];
            wb = 1'b1;
            eAcc = s[3:0];
            eZ = (s[3:0] == 4'h0);
            if (!w[9] && (w[7] ? s[3:0] != 4'h0 : s[3:0] == 4'h0)) nPc = ePc + 14'h2;
        end else if (w[11] && hi <= 4'h3) begin
            case ({hi[1:0], w[9]})
                3'b010, 3'b100: s = m + b;
                3'b000: s = m + b + eC;
                3'b011: s = m - b;
                3'b001: s = m - b - eC;
                3'b101: s = {1'b0, m & b};
                3'b111: s = {1'b0, m | b};
                default: s = {1'b0, m ^ b};
            endcase
            if (hi <= 4'h1) eC = w[9] ? !s[4] : s[4];
            eAcc = s[3:0];
            eZ = (s[3:0] == 4'h0);
            wb = w[8];
        end
        @(posedge clk);
        instWord <= w;
        instValid <= 1'b1;
        @(posedge clk);
        instValid <= 1'b0;
        #1;
        ePc = nPc;
        chk_state();
        chk("ram", 14'(wb ? s[3:0] : m), 14'(mem[a]));
    endtask : run

    task automatic test_add();
        run(16'h2A05, 4'h0);
        run(16'h1805, 4'hF);
        run(16'h1905, 4'h1);
        run(16'h0805, 4'h7);
        run(16'h0905, 4'hF);
        run(16'h0905, 4'h8);
        run(16'h2805, 4'h3);
        run(16'h2905, 4'hD);
    endtask : test_add

    task automatic test_sub();
        run(16'h1A06, 4'h2);
        run(16'h1B06, 4'h1);
        run(16'h0A06, 4'hF);
        run(16'h0B06, 4'h0);
        run(16'h0B06, 4'h0);
    endtask : test_sub

    // Carry is set first so that a logic op clearing it shows up
    task automatic test_logic();
        run(16'h1807, 4'hF);
        run(16'h3A07, 4'hC);
        run(16'h2B07, 4'h6);
        run(16'h3807, 4'h4);
        run(16'h3907, 4'hA);
        run(16'h3B07, 4'h5);
    endtask : test_logic

    task automatic test_imm();
        run(16'h1C34, 4'h5);
        run(16'h1DF4, 4'h1);
        run(16'h0C14, 4'h2);
        run(16'h0D14, 4'hE);
        run(16'h2C1F, 4'hF);
        @(posedge clk);
        workPage <= 3'h2;
        #1;
        run(16'h2DF9, 4'h2);
        run(16'h1E39, 4'h2);
        run(16'h1F29, 4'h7);
        run(16'h0E29, 4'h3);
        run(16'h0F2B, 4'h1);
        run(16'h2E6B, 4'hC);
        run(16'h2F3B, 4'h5);
        run(16'h3E8F, 4'h1);
        run(16'h3F8F, 4'h2);
        run(16'h3C5F, 4'h5);
        run(16'h3D5F, 4'hA);
    endtask : test_imm

    task automatic test_jump();
        run(16'h7123, 4'h0);
        @(posedge clk);
        programBank <= 3'h7;
        #1;
        run(16'h7555, 4'h0);
        run(16'h2A05, 4'h0);
        run(16'h3A05, 4'h5);
        run(16'h8100, 4'h0);
        run(16'h9200, 4'h0);
        run(16'hA300, 4'h0);
        run(16'hB400, 4'h0);
        run(16'hC500, 4'h0);
        run(16'hE600, 4'h0);
        run(16'h2A05, 4'h0);
        run(16'hE700, 4'h0);
        run(16'hC000, 4'h0);
        run(16'h1805, 4'hF);
        run(16'hF100, 4'h0);
        run(16'hD200, 4'h0);
        run(16'h1805, 4'h1);
        run(16'hF300, 4'h0);
        run(16'hD400, 4'h0);
    endtask : test_jump

    task automatic test_skip();
        run(16'h4A07, 4'hF);
        run(16'h4A87, 4'h0);
        run(16'h4807, 4'h1);
        run(16'h4807, 4'h5);
        run(16'h4887, 4'h5);
        run(16'h4887, 4'h1);
        run(16'hA807, 4'h1);
        run(16'hA887, 4'h1);
        run(16'hA907, 4'h4);
        run(16'hA987, 4'h7);
        run(16'hA987, 4'h8);
        run(16'h1000, 4'h3);
    endtask : test_skip

    // A held clock enable must block the write-back as well as the registers
    task automatic test_hold();
        mem[1] = 4'h9;
        @(posedge clk);
        ce <= 1'b0;
        instWord <= 16'h1901;
        instValid <= 1'b1;
        @(posedge clk);
        ce <= 1'b1;
        instValid <= 1'b0;
        #1;
        chk_state();
        chk("ram", 14'h9, 14'(mem[1]));
    endtask : test_hold

    task automatic test_reset();
        @(posedge clk);
        rstn <= 1'b0;
        #1;
        eAcc = 4'h0;
        eZ = 1'b0;
        eC = 1'b0;
        ePc = 14'h0;
        chk_state();
        @(posedge clk);
        rstn <= 1'b1;
        #1;
        run(16'h1805, 4'h2);
    endtask : test_reset

    initial begin
        repeat (3000) @(posedge clk);
        nFail++;
        complete_run();
    end

    initial begin
        foreach (mem[i]) mem[i] = 4'h0;
        rstn = 1'b0;
        ce = 1'b1;
        instValid = 1'b0;
        instWord = 16'h0;
        programBank = 3'h1;
        workPage = 3'h5;
        eAcc = 4'h0;
        eZ = 1'b0;
        eC = 1'b0;
        ePc = 14'h0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk_state();
        test_add();
        test_sub();
        test_logic();
        test_imm();
        test_jump();
        test_skip();
        test_hold();
        test_reset();
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
